/* mmau_defines.vh */
// Constants for the memory map and address unit
`ifndef MMAU_DEFINES_VH
`define MMAU_DEFINES_VH
`define MMAU_AW 16
`define MMAU_DW 16
`define MMAU_MMR_TOP 16'h005f
`define MMAU_AR_BASE 16'h0010
`define MMAU_AR_LAST 16'h0017
`define MMAU_PTR_ADDR 16'h0018
`define MMAU_IDX_ADDR 16'h0019
`define MMAU_GRS_ADDR 16'h001a
`define MMAU_PMS_ADDR 16'h001b
`define MMAU_IOA_BASE 16'h0050
`define MMAU_IOA_TOP 16'h005f
`define MMAU_B2_BASE 16'h0060
`define MMAU_B2_TOP 16'h007f
`define MMAU_B0D_BASE 16'h0100
`define MMAU_B0D_TOP 16'h02ff
`define MMAU_B1_BASE 16'h0300
`define MMAU_B1_TOP 16'h04ff
`define MMAU_B0P_BASE 16'hfe00
`define MMAU_SA_BASE 16'h0800
`define MMAU_SA_TOP 16'h1bff
`define MMAU_ROM_TOP 16'h07ff
`define MMAU_BANK_SH 11
`define MMAU_GRS_MIN 4'h8
`define MMAU_GRS_MAX 4'hf
`define MMAU_PM_ROM 0
`define MMAU_PM_CNF 1
`define MMAU_PM_PROT 2
`define MMAU_BOOT_ALIGN 10
// Control bit selects
`define MMAU_CB_ROM 2'h0
`define MMAU_CB_CNF 2'h1
// Step modes of the address unit
`define MMAU_STEP_NONE 2'h0
`define MMAU_STEP_INC 2'h1
`define MMAU_STEP_DEC 2'h2
`define MMAU_STEP_IDX 2'h3
// Load sources
`define MMAU_SRC_MEM 2'h0
`define MMAU_SRC_ACC 2'h1
`define MMAU_SRC_PRD 2'h2
`define MMAU_SRC_IMM 2'h3
`endif

/* mmau_memory_map_unit.v */
// Auxiliary register file, address unit and memory-space decode
`timescale 1ns/1ps
`include "mmau_defines.vh"
//
// Contract
// RULE1: Eight aux registers chosen by 3-bit pointer
// RULE2: Aux registers, pointer load from four sources
// RULE3: Aux registers mapped in data space
// RULE4: Indirect access steps current register
// RULE5: Three separate 64K-word spaces
// RULE6: Top data region global, size from register
// RULE7: Global accesses raise global bus request
// RULE8: Data 0-5Fh decode to mapped registers
// RULE9: Low 16 I/O ports aliased in data
// RULE10: ROM enable sampled at reset, software changeable
// RULE11: ROM low program addresses, else external
// RULE12: Protection blocks ROM access from external code
// RULE13: Boot source 1K aligned, byte or word
// RULE14: Single-access RAM in independent 2K banks
// RULE15: Only one bank smaller than 2K
// RULE16: Dual RAM reads and writes same cycle
// RULE17: Block one 512, block two 32, data
// RULE18: Block zero data or program by bit
// RULE19: External accesses stretched by ready line; code stalls only on external data reads and fetches, not writes
// RULE20: Up to three accesses per cycle
// RULE21: Register window wins over other regions
// RULE22: Region size code masks upper address bits
module mmau_memory_map_unit (
    // Clock, reset, ROM mode strap and protect option
    input wire ref_clk,
    input wire rst,
    input wire romDisableModeSelect,
    input wire romProtectOption,
    // Core load and step control
    input wire auxLoad,
    input wire ptrLoad,
    input wire [1:0] loadSrc,
    input wire [2:0] loadSel,
    input wire [15:0] memData,
    input wire [15:0] accumulatorData,
    input wire [15:0] productData,
    input wire [15:0] immData,
    input wire indirectAccess,
    input wire [1:0] stepMode,
    input wire idxLoad,
    // Control bit operations
    input wire setControlBitOp,
    input wire clearControlBitOp,
    input wire [1:0] controlBitSel,
    // Data-space port (write and read)
    input wire dataWrite,
    input wire [15:0] dataWrAddr,
    input wire [15:0] dataWrData,
    input wire dataRead,
    input wire [15:0] dataRdAddrDirect,
    input wire useIndirectRead,
    // Program-space port
    input wire progFetch,
    input wire [15:0] progAddr,
    input wire fetchFromExternal,
    // I/O port
    input wire ioLongAccess,
    input wire [15:0] ioAddr,
    // Boot source
    input wire [15:0] bootBase,
    input wire bootByteMode,
    // External side
    input wire extReady,
    // Outputs
    output reg [15:0] dataRdData,
    output reg [15:0] currentAux,
    output reg [2:0] auxPointer,
    output reg [15:0] dataAddrOut,
    output reg selMappedReg,
    output reg selIoAlias,
    output reg selDualRam,
    output reg selSingleRam,
    output reg [2:0] singleRamBank,
    output reg selGlobal,
    output reg globalBusRequest,
    output reg selExtData,
    output reg selRom,
    output reg selExtProg,
    output reg romBlocked,
    output reg selIoPort,
    output reg [15:0] ioAddrOut,
    output reg [15:0] bootAddrOut,
    output reg bootByteOut,
    output reg romEnabled,
    output reg blockZeroProgramSelect,
    output reg waitStall,
    output reg parallelOk
);
    reg [15:0] auxRegs [0:7];
    reg [15:0] idxReg;
    reg [7:0] grsReg;
    reg [2:0] ptr_reg;
    reg romEn_reg;
    reg cnf_reg;
    reg strapPending_reg;
    reg [15:0] loadValue;
    reg [15:0] stepped;
    reg [15:0] rdAddr;
    reg [15:0] globalMask;
    reg inGlobal;
    reg [15:0] mapRead;
    reg [2:0] bankRd;
    reg [2:0] bankWr;
    reg isMapped;
    reg isB0D;
    reg isB1;
    reg isB2;
    reg isSa;
    reg extData;
    reg [3:0] grsCode;
    reg wrMapped;
    reg wrGlobal;
    reg cbRom;
    reg cbCnf;
    reg b0ProgHit;
    reg romHit;
    reg protHit;
    reg extFetch;
    reg extAccess;
    integer i;

    // Load source select
    always @* begin
        if (loadSrc == `MMAU_SRC_MEM) begin
            loadValue = memData; // [RULE2]
        end else if (loadSrc == `MMAU_SRC_ACC) begin
            loadValue = accumulatorData;
        end else if (loadSrc == `MMAU_SRC_PRD) begin
            loadValue = productData;
        end else begin
            loadValue = immData;
        end
    end

    // Post-step of the current register
    always @* begin
        case (stepMode)
            `MMAU_STEP_INC: stepped = auxRegs[ptr_reg] + 16'h0001; // [RULE4]
            `MMAU_STEP_DEC: stepped = auxRegs[ptr_reg] - 16'h0001;
            `MMAU_STEP_IDX: stepped = auxRegs[ptr_reg] + idxReg;
            default: stepped = auxRegs[ptr_reg];
        endcase
    end

    // Read address: indirect uses the current register before stepping
    always @* begin
        rdAddr = useIndirectRead ? auxRegs[ptr_reg] : dataRdAddrDirect; // [RULE1]
    end

    // Global mask; code below minimum means no global region
    always @* begin
        grsCode = grsReg[3:0];
        globalMask = 16'h0000;
        if (grsCode >= `MMAU_GRS_MIN) begin
            // Code n claims the top 2^n words, so 256 up to 32K
            globalMask = ~((16'h0001 << grsCode) - 16'h0001); // [RULE22] [RULE6]
        end
    end

    // Data-space decode; register window checked first
    always @* begin
        isMapped = rdAddr <= `MMAU_MMR_TOP; // [RULE8]
        inGlobal = !isMapped && (globalMask != 16'h0000)
            && ((rdAddr & globalMask) == globalMask); // [RULE6] [RULE21]
        isB2 = !isMapped && !inGlobal && rdAddr >= `MMAU_B2_BASE && rdAddr <= `MMAU_B2_TOP;
        isB0D = !isMapped && !inGlobal && !cnf_reg
            && rdAddr >= `MMAU_B0D_BASE && rdAddr <= `MMAU_B0D_TOP; // [RULE18]
        isB1 = !isMapped && !inGlobal
            && rdAddr >= `MMAU_B1_BASE && rdAddr <= `MMAU_B1_TOP; // [RULE17]
        isSa = !isMapped && !inGlobal && rdAddr >= `MMAU_SA_BASE && rdAddr <= `MMAU_SA_TOP;
        extData = !isMapped && !inGlobal && !isB2 && !isB0D && !isB1 && !isSa;
        // Bank index; the last bank holds the odd remainder
        bankRd = rdAddr[`MMAU_BANK_SH + 2:`MMAU_BANK_SH] - 3'h1; // [RULE14] [RULE15]
        bankWr = dataWrAddr[`MMAU_BANK_SH + 2:`MMAU_BANK_SH] - 3'h1;
        // Writes ask for the global bus on their own address
        wrMapped = dataWrite && dataWrAddr <= `MMAU_MMR_TOP;
        wrGlobal = dataWrite && !wrMapped && (globalMask != 16'h0000)
            && ((dataWrAddr & globalMask) == globalMask); // [RULE7]
    end

    // Mapped register read mux
    always @* begin
        mapRead = 16'h0000;
        if (rdAddr >= `MMAU_AR_BASE && rdAddr <= `MMAU_AR_LAST) begin
            mapRead = auxRegs[rdAddr[2:0]]; // [RULE3]
        end else if (rdAddr == `MMAU_PTR_ADDR) begin
            mapRead = {13'h0000, ptr_reg};
        end else if (rdAddr == `MMAU_IDX_ADDR) begin
            mapRead = idxReg;
        end else if (rdAddr == `MMAU_GRS_ADDR) begin
            mapRead = {8'h00, grsReg};
        end else if (rdAddr == `MMAU_PMS_ADDR) begin
            mapRead = {13'h0000, romProtectOption, cnf_reg, romEn_reg};
        end
    end

    // Control bit selects; the ROM bit belongs to the strap on its edge
    always @* begin
        cbCnf = controlBitSel == `MMAU_CB_CNF;
        cbRom = controlBitSel == `MMAU_CB_ROM && !strapPending_reg;
    end

    // Program decode; block zero in program space is checked before the ROM
    always @* begin
        b0ProgHit = progFetch && cnf_reg && progAddr >= `MMAU_B0P_BASE; // [RULE18]
        romHit = progFetch && !b0ProgHit && romEn_reg && progAddr <= `MMAU_ROM_TOP; // [RULE11]
        protHit = romProtectOption && fetchFromExternal; // [RULE12]
        extFetch = progFetch && !b0ProgHit && !romHit;
        extAccess = (dataRead && (extData || inGlobal)) || extFetch; // [RULE19]
    end

    // Register file and mode state
    always @(posedge ref_clk) begin
        if (rst) begin
            for (i = 0; i < 8; i = i + 1) begin
                auxRegs[i] <= 16'h0000;
            end
            idxReg <= 16'h0000;
            grsReg <= 8'h00;
            ptr_reg <= 3'h0;
            cnf_reg <= 1'b0;
            romEn_reg <= 1'b0;
            strapPending_reg <= 1'b1;
        end else begin
            // Mode strap caught on first edge after release
            strapPending_reg <= 1'b0;
            if (strapPending_reg) begin
                romEn_reg <= !romDisableModeSelect; // [RULE10]
            end
            if (indirectAccess) begin
                auxRegs[ptr_reg] <= stepped; // [RULE4]
            end
            // Explicit load wins over a concurrent step
            if (auxLoad) begin
                auxRegs[loadSel] <= loadValue; // [RULE2]
            end
            if (ptrLoad) begin
                ptr_reg <= loadValue[2:0]; // [RULE1]
            end
            if (idxLoad) begin
                idxReg <= loadValue;
            end
            if (setControlBitOp && cbCnf) begin
                cnf_reg <= 1'b1; // [RULE18]
            end else if (clearControlBitOp && cbCnf) begin
                cnf_reg <= 1'b0;
            end
            if (setControlBitOp && cbRom) begin
                romEn_reg <= 1'b1; // [RULE10]
            end else if (clearControlBitOp && cbRom) begin
                romEn_reg <= 1'b0;
            end
            // Mapped writes
            if (wrMapped) begin
                if (dataWrAddr >= `MMAU_AR_BASE && dataWrAddr <= `MMAU_AR_LAST) begin
                    auxRegs[dataWrAddr[2:0]] <= dataWrData; // [RULE3]
                end else if (dataWrAddr == `MMAU_PTR_ADDR) begin
                    ptr_reg <= dataWrData[2:0];
                end else if (dataWrAddr == `MMAU_IDX_ADDR) begin
                    idxReg <= dataWrData;
                end else if (dataWrAddr == `MMAU_GRS_ADDR) begin
                    grsReg <= dataWrData[7:0]; // [RULE6]
                end else if (dataWrAddr == `MMAU_PMS_ADDR && !strapPending_reg) begin
                    romEn_reg <= dataWrData[`MMAU_PM_ROM]; // [RULE10]
                    cnf_reg <= dataWrData[`MMAU_PM_CNF];
                end
            end
        end
    end

    // Registered outputs
    always @(posedge ref_clk) begin
        if (rst) begin
            dataRdData <= 16'h0000;
            currentAux <= 16'h0000;
            auxPointer <= 3'h0;
            dataAddrOut <= 16'h0000;
            selMappedReg <= 1'b0;
            selIoAlias <= 1'b0;
            selDualRam <= 1'b0;
            selSingleRam <= 1'b0;
            singleRamBank <= 3'h0;
            selGlobal <= 1'b0;
            globalBusRequest <= 1'b0;
            selExtData <= 1'b0;
            selRom <= 1'b0;
            selExtProg <= 1'b0;
            romBlocked <= 1'b0;
            selIoPort <= 1'b0;
            ioAddrOut <= 16'h0000;
            bootAddrOut <= 16'h0000;
            bootByteOut <= 1'b0;
            romEnabled <= 1'b0;
            blockZeroProgramSelect <= 1'b0;
            waitStall <= 1'b0;
            parallelOk <= 1'b0;
        end else begin
            dataRdData <= isMapped ? mapRead : 16'h0000;
            currentAux <= auxRegs[ptr_reg]; // [RULE3]
            auxPointer <= ptr_reg;
            dataAddrOut <= rdAddr; // [RULE5]
            selMappedReg <= dataRead && isMapped; // [RULE8]
            selIoAlias <= dataRead && rdAddr >= `MMAU_IOA_BASE && rdAddr <= `MMAU_IOA_TOP; // [RULE9]
            selDualRam <= dataRead && (isB0D || isB1 || isB2); // [RULE16]
            selSingleRam <= dataRead && isSa; // [RULE14]
            singleRamBank <= bankRd;
            selGlobal <= dataRead && inGlobal;
            globalBusRequest <= (dataRead && inGlobal) || wrGlobal; // [RULE7]
            selExtData <= dataRead && extData;
            // Program decode
            if (b0ProgHit) begin
                selRom <= 1'b0; // [RULE18]
                selExtProg <= 1'b0;
                romBlocked <= 1'b0;
            end else if (romHit) begin
                selRom <= !protHit; // [RULE11] [RULE12]
                selExtProg <= 1'b0;
                romBlocked <= protHit;
            end else begin
                selRom <= 1'b0;
                selExtProg <= progFetch; // [RULE11]
                romBlocked <= 1'b0;
            end
            // Two-word I/O reaches the whole space
            selIoPort <= ioLongAccess; // [RULE9]
            ioAddrOut <= ioAddr;
            bootAddrOut <= {bootBase[15:`MMAU_BOOT_ALIGN], 10'h000}; // [RULE13]
            bootByteOut <= bootByteMode;
            romEnabled <= romEn_reg;
            blockZeroProgramSelect <= cnf_reg;
            // Only external accesses wait on ready
            waitStall <= extAccess && !extReady; // [RULE19]
            // Read and write in different banks or dual RAM run together
            parallelOk <= dataRead && dataWrite
                && ((isB0D || isB1 || isB2) || (isSa && bankRd != bankWr)); // [RULE20] [RULE16]
        end
    end
endmodule

/* mmau_memory_map_props.sv */
// Checker for decode, pointer load and ROM gating
`timescale 1ns/1ps
module mmau_memory_map_props (
    // Clock and reset
    input logic ref_clk,
    input logic rst,
    // Requests
    input logic dataRead,
    input logic useIndirectRead,
    input logic [15:0] dataRdAddrDirect,
    input logic progFetch,
    input logic [15:0] progAddr,
    input logic fetchFromExternal,
    input logic romProtectOption,
    input logic ptrLoad,
    input logic [1:0] loadSrc,
    input logic [15:0] immData,
    // Decode results
    input logic selMappedReg,
    input logic selIoAlias,
    input logic selDualRam,
    input logic selSingleRam,
    input logic [2:0] singleRamBank,
    input logic selGlobal,
    input logic globalBusRequest,
    input logic romEnabled,
    input logic selRom,
    input logic selExtProg,
    input logic romBlocked,
    input logic [2:0] auxPointer
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rd(lo, hi);
        dataRead && !useIndirectRead && dataRdAddrDirect >= lo && dataRdAddrDirect <= hi;
    endsequence
    sequence s_low_fetch;
        progFetch && progAddr <= 16'h07ff;
    endsequence
    a_window_low: assert property (s_rd(16'h0000, 16'h005f) |=> selMappedReg && !selDualRam)
        else $error("mapped window missed");
    a_io_alias: assert property (s_rd(16'h0050, 16'h005f) |=> selIoAlias)
        else $error("io alias missed");
    a_block_two: assert property (s_rd(16'h0060, 16'h007f) |=> selDualRam && !selMappedReg)
        else $error("block two missed");
    a_bank_select: assert property (s_rd(16'h0800, 16'h1bff) |=> selSingleRam
        && singleRamBank == $past(dataRdAddrDirect[13:11]) - 3'h1) else $error("bank wrong");
    a_global_request: assert property (selGlobal |-> globalBusRequest)
        else $error("no bus request");
    a_rom_decode: assert property (s_low_fetch and !fetchFromExternal |=>
        selRom == $past(romEnabled) && selExtProg != $past(romEnabled)) else $error("rom decode");
    a_rom_protect: assert property (s_low_fetch and fetchFromExternal && romProtectOption
        && romEnabled |=> romBlocked && !selRom) else $error("rom not blocked");
    a_pointer_load: assert property (ptrLoad && loadSrc == 2'h3 |=> ##1
        auxPointer == $past(immData[2:0], 2)) else $error("pointer load");
endmodule

/* mmau_ext_mem_model.sv */
// External memory that answers promptly or slowly
`timescale 1ns/1ps
module mmau_ext_mem_model (
    // Clock and reset
    input logic ref_clk,
    input logic rst,
    // Access from the device
    input logic selExtData,
    input logic selExtProg,
    input logic [1:0] waitStates,
    // Ready back to the device
    output logic extReady
);
    logic [1:0] cntReg;
    logic selPrev;
    logic start;
    assign start = (selExtData || selExtProg) && !selPrev && waitStates != 2'h0;
    always @(posedge ref_clk) begin
        selPrev <= rst ? 1'b0 : (selExtData || selExtProg);
        if (rst) begin
            cntReg <= 2'h0;
        end else if (start) begin
            cntReg <= waitStates - 2'h1;
        end else if (cntReg != 2'h0) begin
            cntReg <= cntReg - 2'h1;
        end
    end
    // Slow part holds ready low for the set count
    assign extReady = !start && cntReg == 2'h0;
endmodule

/* tb_top.sv */
// Testbench for the memory map and address unit
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rst, romDisableModeSelect, romProtectOption, auxLoad, ptrLoad, idxLoad;
    logic indirectAccess, setControlBitOp, clearControlBitOp, dataWrite, dataRead;
    logic useIndirectRead, progFetch, fetchFromExternal, ioLongAccess, bootByteMode, extReady;
    logic [1:0] loadSrc, stepMode, controlBitSel, waitStates;
    logic [2:0] loadSel, auxPointer, singleRamBank;
    logic [15:0] memData, accumulatorData, productData, immData, dataWrAddr, dataWrData;
    logic [15:0] dataRdAddrDirect, progAddr, ioAddr, bootBase, dataRdData, currentAux;
    logic [15:0] dataAddrOut, ioAddrOut, bootAddrOut;
    logic selMappedReg, selIoAlias, selDualRam, selSingleRam, selGlobal, globalBusRequest;
    logic selExtData, selRom, selExtProg, romBlocked, selIoPort, bootByteOut, romEnabled;
    logic blockZeroProgramSelect, waitStall, parallelOk;
    int nMismatch, checked, cycles;
    mmau_memory_map_unit mmau_memory_map_unit_i (.ref_clk, .rst, .romDisableModeSelect,
        .romProtectOption, .auxLoad, .ptrLoad, .loadSrc, .loadSel, .memData, .accumulatorData,
        .productData, .immData, .indirectAccess, .stepMode, .idxLoad, .setControlBitOp,
        .clearControlBitOp, .controlBitSel, .dataWrite, .dataWrAddr, .dataWrData, .dataRead,
        .dataRdAddrDirect, .useIndirectRead, .progFetch, .progAddr, .fetchFromExternal,
        .ioLongAccess, .ioAddr, .bootBase, .bootByteMode, .extReady, .dataRdData, .currentAux,
        .auxPointer, .dataAddrOut, .selMappedReg, .selIoAlias, .selDualRam, .selSingleRam,
        .singleRamBank, .selGlobal, .globalBusRequest, .selExtData, .selRom, .selExtProg,
        .romBlocked, .selIoPort, .ioAddrOut, .bootAddrOut, .bootByteOut, .romEnabled,
        .blockZeroProgramSelect, .waitStall, .parallelOk);
    mmau_ext_mem_model mmau_ext_mem_model_i (.ref_clk, .rst, .selExtData, .selExtProg,
        .waitStates, .extReady);
    task automatic test_done;
        $display("TB: checks %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(logic [15:0] a);
        @(posedge ref_clk);
        dataRead <= 1;
        dataRdAddrDirect <= a;
        @(posedge ref_clk);
        dataRead <= 0;
        #1;
    endtask
    task automatic ctl(logic s, logic [1:0] b);
        @(posedge ref_clk);
        setControlBitOp <= s;
        clearControlBitOp <= !s;
        controlBitSel <= b;
        @(posedge ref_clk);
        {setControlBitOp, clearControlBitOp} <= 2'h0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic ft(logic x, logic [2:0] e);
        @(posedge ref_clk);
        progFetch <= 1;
        progAddr <= 16'h0100;
        fetchFromExternal <= x;
        @(posedge ref_clk);
        progFetch <= 0;
        #1 chk({selRom, selExtProg, romBlocked}, e);
    endtask
    task automatic t_load;
        logic [15:0] v[4] = '{16'h1a02, 16'h2b02, 16'h3c02, 16'h0102};
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk);
            {auxLoad, ptrLoad} <= 2'h3;
            loadSrc <= s[1:0];
            @(posedge ref_clk);
            {auxLoad, ptrLoad} <= 2'h0;
            @(posedge ref_clk);
            #1 chk(currentAux, v[s]);
            chk(auxPointer, 2);
        end
    endtask
    task automatic t_step;
        logic [15:0] a = 16'h0102;
        @(posedge ref_clk);
        idxLoad <= 1;
        immData <= 16'h0010;
        @(posedge ref_clk);
        idxLoad <= 0;
        for (int i = 1; i < 5; i++) begin
            @(posedge ref_clk);
            {dataRead, useIndirectRead, indirectAccess} <= 3'h7;
            stepMode <= i[1:0];
            @(posedge ref_clk);
            {dataRead, useIndirectRead, indirectAccess} <= 3'h0;
            #1 chk(dataAddrOut, a);
            a = a + (i == 1 ? 16'h1 : i == 2 ? 16'hffff : i == 3 ? 16'h10 : 16'h0);
            @(posedge ref_clk);
            #1 chk(currentAux, a);
        end
    endtask
    task automatic t_map;
        logic [15:0] ad[8] = '{16'h0012, 16'h0055, 16'h0060, 16'h0800, 16'h1bff, 16'hff80,
            16'hfe80, 16'h2000};
        logic [9:0] fl[8] = '{10'h200, 10'h300, 10'h080, 10'h040, 10'h042, 10'h030, 10'h008,
            10'h008};
        @(posedge ref_clk);
        dataWrite <= 1;
        dataWrAddr <= 16'h001a;
        dataWrData <= 16'h0008;
        @(posedge ref_clk);
        dataWrite <= 0;
        for (int i = 0; i < 8; i++) begin
            rd(ad[i]);
            chk({selMappedReg, selIoAlias, selDualRam, selSingleRam, selGlobal,
                globalBusRequest, selExtData}, fl[i][9:3]);
            if (fl[i][6]) chk(singleRamBank, fl[i][2:0]);
            if (i == 0) chk(dataRdData, 16'h0112);
        end
        @(posedge ref_clk);
        dataWrite <= 1;
        dataWrData <= 16'h000f;
        @(posedge ref_clk);
        dataWrite <= 0;
        rd(16'h8000);
        chk(selGlobal, 1);
        rd(16'h7fff);
        chk(selGlobal, 0);
    endtask
    task automatic t_par;
        logic [15:0] ra[3] = '{16'h0800, 16'h0800, 16'h0060};
        logic [15:0] wa[3] = '{16'h1000, 16'h0900, 16'h0060};
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            {dataRead, dataWrite} <= 2'h3;
            dataRdAddrDirect <= ra[i];
            dataWrAddr <= wa[i];
            @(posedge ref_clk);
            {dataRead, dataWrite} <= 2'h0;
            #1 chk(parallelOk, i != 1);
        end
    endtask
    task automatic t_rom;
        @(posedge ref_clk);
        #1 chk(romEnabled, 1);
        ft(0, 3'h4);
        ctl(0, 2'h0);
        chk(romEnabled, 0);
        ft(0, 3'h2);
        ctl(1, 2'h0);
        @(posedge ref_clk);
        romProtectOption <= 1;
        ft(1, 3'h1);
        ft(0, 3'h4);
    endtask
    task automatic t_blk0;
        ctl(1, 2'h1);
        chk(blockZeroProgramSelect, 1);
        rd(16'h0100);
        chk(selDualRam, 0);
        ctl(0, 2'h1);
        rd(16'h0100);
        chk(selDualRam, 1);
    endtask
    task automatic t_wait;
        int n = 0;
        @(posedge ref_clk);
        waitStates <= 2'h2;
        dataRead <= 1;
        dataRdAddrDirect <= 16'h2000;
        while (waitStall !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n < 8, 1);
        while (waitStall !== 1'b0 && n < 16) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n < 16, 1);
        @(posedge ref_clk);
        waitStates <= 2'h0;
        dataRead <= 0;
        repeat (4) @(posedge ref_clk);
        dataRead <= 1;
        repeat (3) begin
            @(posedge ref_clk);
            #1 chk(waitStall, 0);
        end
        @(posedge ref_clk);
        dataRead <= 0;
    endtask
    task automatic t_misc;
        @(posedge ref_clk);
        {bootByteMode, ioLongAccess} <= 2'h3;
        bootBase <= 16'h1234;
        ioAddr <= 16'hbeef;
        @(posedge ref_clk);
        ioLongAccess <= 0;
        #1 chk(bootAddrOut, 16'h1000);
        chk(bootByteOut, 1);
        chk(ioAddrOut, 16'hbeef);
        chk(selIoPort, 1);
    endtask
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard well above the longest sequence
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            test_done;
        end
    end
    initial begin
        {nMismatch, checked, cycles} = '0;
        rst = 1;
        {romDisableModeSelect, romProtectOption, auxLoad, ptrLoad, idxLoad, indirectAccess} = '0;
        {setControlBitOp, clearControlBitOp, dataWrite, dataRead, useIndirectRead} = '0;
        {progFetch, fetchFromExternal, ioLongAccess, bootByteMode, stepMode, controlBitSel} = '0;
        {waitStates, dataWrAddr, dataWrData, dataRdAddrDirect, progAddr, ioAddr, bootBase} = '0;
        {loadSrc, loadSel} = 5'h02;
        {memData, accumulatorData, productData} = {16'h1a02, 16'h2b02, 16'h3c02};
        immData = 16'h0102;
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        t_rom;
        t_load;
        t_step;
        t_map;
        t_par;
        t_blk0;
        t_wait;
        t_misc;
        test_done;
    end
endmodule
bind mmau_memory_map_unit mmau_memory_map_props mmau_memory_map_props_i (.ref_clk, .rst,
    .dataRead, .useIndirectRead, .dataRdAddrDirect, .progFetch, .progAddr, .fetchFromExternal,
    .romProtectOption, .ptrLoad, .loadSrc, .immData, .selMappedReg, .selIoAlias, .selDualRam,
    .selSingleRam, .singleRamBank, .selGlobal, .globalBusRequest, .romEnabled, .selRom,
    .selExtProg, .romBlocked, .auxPointer);
